/* File: core/cht_host_port.sv */
// Codec host transfer port: registers, PIO and DMA sample transfers
`timescale 1ns/1ps
`default_nettype none
module cht_host_port
  import cht_pkg::*;
#(
  parameter int SAMPLE_W = 32
)(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [1:0] address_lines,
  input wire logic [7:0] host_byte_bus_in,
  output logic [7:0] host_byte_bus_out,
  output logic host_byte_bus_oe,
  input wire logic playback_dma_ack_n,
  input wire logic capture_dma_ack_n,
  output logic playback_dma_request,
  output logic capture_dma_request,
  output logic irq,
  output logic [1:0] external_control_bits,
  input wire logic sample_start,
  input wire logic capture_point,
  input wire logic [SAMPLE_W-1:0] capture_sample_in,
  output logic [SAMPLE_W-1:0] playback_sample_out,
  output logic playback_sample_strobe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic rd_d_r, wr_d_r;
  logic [7:0] index_r, format_r, iface_r, pin_r, base_hi_r, base_lo_r;
  logic [7:0] index_nxt, format_nxt, iface_nxt, pin_nxt;
  logic [7:0] base_hi_nxt, base_lo_nxt;
  logic [15:0] count_r, count_nxt;
  logic int_r, int_nxt;
  logic [1:0] ext_ctl_r, ext_ctl_nxt;
  logic play_req_r, play_req_nxt, cap_req_r, cap_req_nxt;
  logic play_ready_r, play_ready_nxt, cap_ready_r, cap_ready_nxt;
  logic play_full_r, play_full_nxt;
  logic [SAMPLE_W-1:0] play_buf_r, play_buf_nxt, cap_buf_r, cap_buf_nxt;
  logic [SAMPLE_W-1:0] play_out_r, play_out_nxt;
  logic play_stb_r, play_stb_nxt;
  cht_cyc_t wcyc_r, wcyc_nxt;
  logic [1:0] waddr_r, waddr_nxt, wlane_r, wlane_nxt;
  logic wlast_r, wlast_nxt;
  logic [7:0] dout_r, dout_nxt;
  logic oe_r, oe_nxt;

  logic rd_fall, wr_fall, wr_rise;
  logic prun, crun, single, stereo, wide;
  logic play_pio, cap_pio, play_dma, cap_dma, sc_cap;
  logic p_ack, c_ack, direct, count_run, load_count;
  logic play_step, cap_step, play_last, cap_last;
  logic [1:0] play_idx, cap_idx, cap_lane;
  logic [7:0] reg_rd, status;

  assign rd_fall = rd_d_r & ~rd_n;
  assign wr_fall = wr_d_r & ~wr_n;
  assign wr_rise = ~wr_d_r & wr_n; // R11
  assign prun = iface_r[IF_PLAY_RUN_BIT];
  assign crun = iface_r[IF_CAP_RUN_BIT];
  assign single = iface_r[IF_SINGLE_BIT];
  assign stereo = format_r[FMT_STEREO_BIT];
  assign wide = format_r[FMT_WIDE_BIT];
  // Each direction decodes its own mode
  assign play_pio = prun & iface_r[IF_PLAY_PIO_BIT]; // R4 R9
  assign cap_pio = crun & iface_r[IF_CAP_PIO_BIT]; // R9
  assign sc_cap = single & ~prun & crun; // R20 R22
  assign play_dma = prun & ~iface_r[IF_PLAY_PIO_BIT]; // R14
  assign cap_dma = crun & ~iface_r[IF_CAP_PIO_BIT] & (~single | sc_cap); // R14
  // Acknowledge routing; address and chip select unused under ack
  assign p_ack = ~playback_dma_ack_n & ~sc_cap; // R15
  assign c_ack = single ? (~playback_dma_ack_n & sc_cap)
                        : ~capture_dma_ack_n; // R19 R15
  // Direct cycles only with both acks idle
  assign direct = ~cs_n & playback_dma_ack_n & capture_dma_ack_n; // R8 R10

  assign cap_step = rd_fall & (c_ack |
      (direct & (address_lines == ADDR_PIO) & cap_pio));
  assign play_step = wr_fall & (p_ack |
      (direct & (address_lines == ADDR_PIO) & play_pio));
  assign cap_lane = cht_lane(cap_idx, wide); // R6 R7

  cht_byte_seq u_play_seq (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(sample_start),
    .step(play_step),
    .stereo(stereo),
    .wide(wide),
    .byte_idx(play_idx),
    .last_byte(play_last)
  );

  cht_byte_seq u_cap_seq (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(capture_point & ~cap_ready_r),
    .step(cap_step),
    .stereo(stereo),
    .wide(wide),
    .byte_idx(cap_idx),
    .last_byte(cap_last)
  );

  assign status = ({7'h00, int_r} << ST_INT_BIT) |
                  ({7'h00, play_ready_r} << ST_PLAY_READY_BIT) |
                  ({7'h00, cap_ready_r} << ST_CAP_READY_BIT);

  // Indexed read mux; running counter has no read path
  always_comb begin
    case (index_r[INDEX_LSB +: 4])
      IDX_FORMAT: reg_rd = format_r;
      IDX_IFACE: reg_rd = iface_r;
      IDX_PIN: reg_rd = pin_r;
      IDX_BASE_HI: reg_rd = base_hi_r; // R1 R3
      IDX_BASE_LO: reg_rd = base_lo_r; // R2 R3
      default: reg_rd = 8'h00;
    endcase
  end

  assign count_run = (prun | crun) & (~pin_r[PIN_HOLD_BIT] | ~int_r);
  assign load_count = wr_rise & (wcyc_r == CYC_DIRECT) &
      (waddr_r == ADDR_DATA) & (index_r[INDEX_LSB +: 4] == IDX_BASE_HI);

  // Host registers, counter and interrupt
  always_comb begin
    index_nxt = index_r;
    format_nxt = format_r;
    iface_nxt = iface_r;
    pin_nxt = pin_r;
    base_hi_nxt = base_hi_r;
    base_lo_nxt = base_lo_r;
    count_nxt = count_r;
    int_nxt = int_r;
    ext_ctl_nxt = ext_ctl_r;
    if (wr_rise && wcyc_r == CYC_DIRECT) begin
      case (waddr_r)
        ADDR_INDEX: index_nxt = host_byte_bus_in;
        ADDR_DATA: begin
          case (index_r[INDEX_LSB +: 4])
            IDX_FORMAT: format_nxt = host_byte_bus_in;
            IDX_IFACE: iface_nxt = host_byte_bus_in;
            IDX_PIN: pin_nxt = host_byte_bus_in;
            IDX_BASE_HI: base_hi_nxt = host_byte_bus_in; // R1
            IDX_BASE_LO: base_lo_nxt = host_byte_bus_in; // R2
            default: ;
          endcase
        end
        ADDR_STATUS: int_nxt = 1'b0; // R25
        default: ;
      endcase
    end
    if (load_count) begin
      count_nxt = {host_byte_bus_in, base_lo_r}; // R23
    end else if (sample_start && count_run) begin
      if (count_r == 16'h0000) begin
        count_nxt = {base_hi_r, base_lo_r}; // R24
      end else begin
        count_nxt = count_r - 16'h0001; // R24
      end
    end
    if (sample_start && count_run && count_r == 16'h0000 && !load_count) begin
      int_nxt = 1'b1; // R24
    end
    if (sample_start) begin
      ext_ctl_nxt = pin_r[PIN_EXT_CTL_LSB +: 2]; // R13
    end
  end

  // Sample buffers, ready flags, requests and bus cycles
  always_comb begin
    play_req_nxt = play_req_r;
    cap_req_nxt = cap_req_r;
    play_ready_nxt = play_ready_r;
    cap_ready_nxt = cap_ready_r;
    play_full_nxt = play_full_r & ~sample_start;
    play_buf_nxt = play_buf_r;
    cap_buf_nxt = cap_buf_r;
    play_out_nxt = play_out_r;
    play_stb_nxt = 1'b0;
    wcyc_nxt = wcyc_r;
    waddr_nxt = waddr_r;
    wlane_nxt = wlane_r;
    wlast_nxt = wlast_r;
    dout_nxt = dout_r;
    oe_nxt = oe_r & ~rd_n;
    if (wr_fall) begin
      waddr_nxt = address_lines;
      wlane_nxt = cht_lane(play_idx, wide); // R6 R7
      wlast_nxt = play_last;
      if (play_step) begin
        wcyc_nxt = CYC_PLAY;
      end else if (direct) begin
        wcyc_nxt = CYC_DIRECT;
      end else begin
        wcyc_nxt = CYC_NONE;
      end
    end
    if (play_step && play_last) begin
      play_req_nxt = 1'b0; // R17
      play_ready_nxt = 1'b0;
    end
    if (wr_rise && wcyc_r == CYC_PLAY) begin
      play_buf_nxt[{wlane_r, 3'b000} +: 8] = host_byte_bus_in; // R11
      if (wlast_r) begin
        play_full_nxt = 1'b1;
      end
    end
    if (sample_start) begin
      if (play_full_r) begin
        play_out_nxt = play_buf_r;
        play_stb_nxt = 1'b1;
      end
      play_ready_nxt = prun | play_ready_nxt;
      play_req_nxt = play_dma | play_req_nxt; // R16 R14
    end
    if (rd_fall) begin
      oe_nxt = c_ack | direct; // R11
      if (c_ack) begin
        dout_nxt = cap_buf_r[{cap_lane, 3'b000} +: 8]; // R15
      end else begin
        case (address_lines)
          ADDR_INDEX: dout_nxt = index_r;
          ADDR_DATA: dout_nxt = reg_rd;
          ADDR_STATUS: dout_nxt = status;
          default: dout_nxt = cap_pio ? cap_buf_r[{cap_lane, 3'b000} +: 8]
                                      : 8'h00;
        endcase
      end
    end
    // Request stays up after a run bit clears until serviced
    if (cap_step && cap_last) begin
      cap_req_nxt = 1'b0; // R17 R18
      cap_ready_nxt = 1'b0;
    end
    // Late-period load; overrun keeps the unread sample
    if (capture_point && crun && !cap_ready_r) begin
      cap_buf_nxt = capture_sample_in;
      cap_ready_nxt = 1'b1; // R12
      cap_req_nxt = cap_dma | cap_req_nxt; // R16 R14
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_d_r <= 1'b1;
      wr_d_r <= 1'b1;
      index_r <= RST_INDEX;
      format_r <= RST_FORMAT;
      iface_r <= RST_IFACE;
      pin_r <= RST_PIN;
      base_hi_r <= RST_BASE;
      base_lo_r <= RST_BASE;
      count_r <= 16'h0000;
      int_r <= 1'b0;
      ext_ctl_r <= 2'h0;
      play_req_r <= 1'b0;
      cap_req_r <= 1'b0;
      play_ready_r <= 1'b0;
      cap_ready_r <= 1'b0;
      play_full_r <= 1'b0;
      play_buf_r <= '0;
      cap_buf_r <= '0;
      play_out_r <= '0;
      play_stb_r <= 1'b0;
      wcyc_r <= CYC_NONE;
      waddr_r <= 2'h0;
      wlane_r <= 2'h0;
      wlast_r <= 1'b0;
      dout_r <= 8'h00;
      oe_r <= 1'b0;
    end else begin
      rd_d_r <= rd_n;
      wr_d_r <= wr_n;
      index_r <= index_nxt;
      format_r <= format_nxt;
      iface_r <= iface_nxt;
      pin_r <= pin_nxt;
      base_hi_r <= base_hi_nxt;
      base_lo_r <= base_lo_nxt;
      count_r <= count_nxt;
      int_r <= int_nxt;
      ext_ctl_r <= ext_ctl_nxt;
      play_req_r <= play_req_nxt;
      cap_req_r <= cap_req_nxt;
      play_ready_r <= play_ready_nxt;
      cap_ready_r <= cap_ready_nxt;
      play_full_r <= play_full_nxt;
      play_buf_r <= play_buf_nxt;
      cap_buf_r <= cap_buf_nxt;
      play_out_r <= play_out_nxt;
      play_stb_r <= play_stb_nxt;
      wcyc_r <= wcyc_nxt;
      waddr_r <= waddr_nxt;
      wlane_r <= wlane_nxt;
      wlast_r <= wlast_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
    end
  end

  // Single channel: capture request moves to the playback pin
  assign playback_dma_request = sc_cap ? cap_req_r : play_req_r; // R19
  assign capture_dma_request = cap_req_r & ~single; // R19
  assign irq = int_r & pin_r[PIN_IRQ_EN_BIT]; // R25
  assign external_control_bits = ext_ctl_r;
  assign host_byte_bus_out = dout_r;
  assign host_byte_bus_oe = oe_r & ~rd_n; // R11
  assign playback_sample_out = play_out_r;
  assign playback_sample_strobe = play_stb_r;

  sequence s_hi_write;
    load_count;
  endsequence

  sequence s_underflow;
    sample_start && count_run && count_r == 16'h0000 && !load_count;
  endsequence

  a_single_cap_low: assert property (single |-> !capture_dma_request) // R19
    else $error("capture request high in single channel mode");
  a_req_holds: assert property (play_req_r && // R17
    !(play_step && play_last) |=> play_req_r)
    else $error("playback request dropped before final byte");
  a_req_drops: assert property (play_step && play_last && // R17
    !sample_start |=> !play_req_r)
    else $error("playback request not dropped after final byte");
  a_count_load: assert property (s_hi_write |=> // R23
    count_r == {base_hi_r, base_lo_r})
    else $error("counter not loaded from base bytes");
  a_int_set: assert property (s_underflow |=> // R24
    int_r && count_r == {base_hi_r, base_lo_r})
    else $error("underflow did not set flag and reload");
  a_count_dec: assert property (sample_start && count_run && // R24
    count_r != 16'h0000 && !load_count
    |=> count_r == $past(count_r) - 16'h0001)
    else $error("counter did not decrement");
  a_irq_clear: assert property (wr_rise && wcyc_r == CYC_DIRECT && // R25
    waddr_r == ADDR_STATUS && !sample_start |=> !irq)
    else $error("status write did not clear interrupt");
  a_irq_gate: assert property (!pin_r[PIN_IRQ_EN_BIT] |-> !irq) // R25
    else $error("interrupt high while disabled");
  a_ext_ctl_follow: assert property (sample_start |=> // R13
    external_control_bits == $past(pin_r[PIN_EXT_CTL_LSB +: 2]))
    else $error("external control pins did not follow");
  a_pio_no_req: assert property (sample_start && play_pio && // R9
    !play_req_r |=> !play_req_r)
    else $error("request raised in playback PIO mode");
  a_dma_req: assert property (sample_start && play_dma |=> // R14 R16
    play_req_r)
    else $error("playback DMA request not raised");
endmodule : cht_host_port
`default_nettype wire

/* File: pkg/cht_pkg.sv */
// Package: constants, types and helpers of the codec host transfer port
// Function
// R1 - Upper base byte stored, reads back written
// R2 - Lower base byte stored, reads back written
// R3 - Running sample counter is never readable
// R4 - Each direction picks PIO or DMA independently
// R5 - Host services each sample before next conversion
// R6 - Sixteen-bit samples move low byte first
// R7 - Left channel bytes precede right channel bytes
// R8 - Registers reachable only by chip-selected cycles
// R9 - PIO when run and I/O select set
// R10 - Host keeps acknowledges high during direct cycles
// R11 - Drive bus while read low; latch write rise
// R12 - Capture ready rises before playback ready; code raises playback ready at sample_start, capture ready at capture_point
// R13 - Pin bits reach output pins within period
// R14 - DMA when run set and I/O select clear
// R15 - Acknowledged cycles ignore address and chip select
// R16 - Playback request early, capture request late
// R17 - Request held until final byte strobe falls
// R18 - Host completes pending request after run cleared
// R19 - Single channel: capture on playback pins
// R20 - Single channel: playback wins when both run
// R21 - Host clears runs before switching direction
// R22 - Direction switches by run bits alone
// R23 - Upper byte write loads running counter
// R24 - Counter decrements, underflow sets flag, reloads
// R25 - Interrupt pin gated by enable; status write clears
// R26 - Byte count per sample follows format
package cht_pkg;
  // Direct addresses on the two address lines
  localparam logic [1:0] ADDR_INDEX = 2'h0;
  localparam logic [1:0] ADDR_DATA = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam logic [1:0] ADDR_PIO = 2'h3;
  // Indexed registers
  localparam logic [3:0] IDX_FORMAT = 4'h8;
  localparam logic [3:0] IDX_IFACE = 4'h9;
  localparam logic [3:0] IDX_PIN = 4'hA;
  localparam logic [3:0] IDX_BASE_HI = 4'hE;
  localparam logic [3:0] IDX_BASE_LO = 4'hF;
  // Index register fields
  localparam int INDEX_LSB = 0;
  localparam int MODE_GATE_BIT = 6;
  // Format register fields
  localparam int FMT_STEREO_BIT = 4;
  localparam int FMT_WIDE_BIT = 6;
  // Interface configuration fields
  localparam int IF_PLAY_RUN_BIT = 0;
  localparam int IF_CAP_RUN_BIT = 1;
  localparam int IF_SINGLE_BIT = 2;
  localparam int IF_PLAY_PIO_BIT = 6;
  localparam int IF_CAP_PIO_BIT = 7;
  // Pin control fields
  localparam int PIN_IRQ_EN_BIT = 1;
  localparam int PIN_HOLD_BIT = 2;
  localparam int PIN_EXT_CTL_LSB = 6;
  // Status register fields
  localparam int ST_INT_BIT = 0;
  localparam int ST_PLAY_READY_BIT = 1;
  localparam int ST_CAP_READY_BIT = 5;
  // Reset values
  localparam logic [7:0] RST_INDEX = 8'h00;
  localparam logic [7:0] RST_FORMAT = 8'h00;
  localparam logic [7:0] RST_IFACE = 8'h08;
  localparam logic [7:0] RST_PIN = 8'h00;
  localparam logic [7:0] RST_BASE = 8'h00;

  typedef enum logic [1:0] {CYC_NONE, CYC_DIRECT, CYC_PLAY} cht_cyc_t;

  // Byte lane of a sample word {R hi, R lo, L hi, L lo}
  function automatic logic [1:0] cht_lane(input logic [1:0] idx,
                                          input logic wide);
    cht_lane = wide ? idx : {idx[0], 1'b1};
  endfunction : cht_lane

  // Index of the final byte of one sample
  function automatic logic [1:0] cht_last_idx(input logic stereo,
                                              input logic wide);
    cht_last_idx = {stereo & wide, stereo | wide};
  endfunction : cht_last_idx
endpackage : cht_pkg

/* File: core/cht_byte_seq.sv */
// Byte position counter within one sample transfer
`timescale 1ns/1ps
`default_nettype none
module cht_byte_seq
  import cht_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic step,
  input wire logic stereo,
  input wire logic wide,
  output logic [1:0] byte_idx,
  output logic last_byte
);
  logic [1:0] idx_r;
  logic [1:0] idx_nxt;

  assign byte_idx = idx_r;
  assign last_byte = (idx_r == cht_last_idx(stereo, wide)); // R26

  always_comb begin
    idx_nxt = idx_r;
    if (clear) begin
      idx_nxt = 2'h0;
    end else if (step) begin
      idx_nxt = last_byte ? 2'h0 : idx_r + 2'h1; // R26
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      idx_r <= 2'h0;
    end else begin
      idx_r <= idx_nxt;
    end
  end
endmodule : cht_byte_seq
`default_nettype wire

/* File: tb/cht_host_model.sv */
// Host CPU and DMA controller model on the far side of the host port
`timescale 1ns/1ps
`default_nettype none
module cht_host_model (
  input wire logic ref_clk,
  input wire logic [7:0] bus_out,
  input wire logic bus_oe,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [1:0] addr,
  output logic [7:0] drv,
  output logic play_ack_n,
  output logic cap_ack_n
);
  int hold = 3;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 2'h0;
    drv = 8'h00;
    play_ack_n = 1'b1;
    cap_ack_n = 1'b1;
  end
  task automatic step();
    @(posedge ref_clk);
    #5;
  endtask : step
  // Strobe held low, data kept across the rising edge, then inverted
  task automatic cyc(input logic is_rd, input logic [7:0] d,
                     output logic [7:0] q, output logic oe);
    rd_n = ~is_rd;
    wr_n = is_rd;
    drv = d;
    repeat (hold) step();
    q = bus_out;
    oe = bus_oe;
    rd_n = 1'b1;
    wr_n = 1'b1;
    step();
    drv = ~d;
  endtask : cyc
  task automatic reg_acc(input logic is_rd, input logic [1:0] a,
                         input logic [7:0] d, output logic [7:0] q,
                         output logic oe);
    play_ack_n = 1'b1;
    cap_ack_n = 1'b1;
    cs_n = 1'b0;
    addr = a;
    cyc(is_rd, d, q, oe);
    cs_n = 1'b1;
    step();
  endtask : reg_acc
  // Acknowledged byte; select and address left in junk states
  task automatic dma(input logic play, input logic is_rd,
                     input logic [7:0] d, output logic [7:0] q);
    logic oe;
    cs_n = 1'b0;
    addr = ~addr;
    play_ack_n = ~play;
    cap_ack_n = play;
    cyc(is_rd, d, q, oe);
    play_ack_n = 1'b1;
    cap_ack_n = 1'b1;
    cs_n = 1'b1;
    step();
  endtask : dma
endmodule : cht_host_model
`default_nettype wire

/* File: tb/cht_host_port_tb.sv */
// Self-checking bench of the codec host transfer port
`timescale 1ns/1ps
`default_nettype none
module cht_host_port_tb;
  import cht_pkg::*;
  logic ref_clk, rst, cs_n, rd_n, wr_n, bus_oe, pack_n, cack_n;
  logic preq, creq, irq, sstart, cpoint, strobe, oe_seen, seen;
  logic [1:0] addr, ext_ctl;
  logic [7:0] drv, bus_out, bus_w, q;
  logic [31:0] cap_in, play_out, word;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  assign bus_w = bus_oe ? bus_out : drv;
  cht_host_port #(.SAMPLE_W(32)) i_dut (.ref_clk(ref_clk), .rst(rst),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .address_lines(addr),
    .host_byte_bus_in(bus_w), .host_byte_bus_out(bus_out),
    .host_byte_bus_oe(bus_oe), .playback_dma_ack_n(pack_n),
    .capture_dma_ack_n(cack_n), .playback_dma_request(preq),
    .capture_dma_request(creq), .irq(irq), .external_control_bits(ext_ctl),
    .sample_start(sstart), .capture_point(cpoint),
    .capture_sample_in(cap_in), .playback_sample_out(play_out),
    .playback_sample_strobe(strobe));
  cht_host_model i_host (.ref_clk(ref_clk), .bus_out(bus_out),
    .bus_oe(bus_oe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .drv(drv), .play_ack_n(pack_n), .cap_ack_n(cack_n));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic conclude();
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic chk8(input string n, input logic [7:0] e, g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk8
  task automatic chk1(input string n, input logic e, g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %b seen %b", n, e, g);
    end
  endtask : chk1
  task automatic chk32(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk32
  task automatic step();
    @(posedge ref_clk);
    #5;
  endtask : step
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    i_host.reg_acc(1'b0, a, d, q, oe_seen);
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e,
                    input string n);
    i_host.reg_acc(1'b1, a, 8'h00, q, oe_seen);
    chk1("read_oe", 1'b1, oe_seen);
    chk8(n, e, q);
  endtask : rd
  task automatic iw(input logic [3:0] idx, input logic [7:0] v);
    wr(ADDR_INDEX, {4'h0, idx});
    wr(ADDR_DATA, v);
  endtask : iw
  task automatic ir(input logic [3:0] idx, input logic [7:0] e,
                    input string n);
    wr(ADDR_INDEX, {4'h0, idx});
    rd(ADDR_DATA, e, n);
  endtask : ir
  task automatic stat();
    i_host.reg_acc(1'b1, ADDR_STATUS, 8'h00, q, oe_seen);
  endtask : stat
  // One sample period start; catches the playback hand-over pulse
  task automatic period();
    sstart = 1'b1;
    step();
    sstart = 1'b0;
    seen = 1'b0;
    repeat (4) begin
      if (strobe === 1'b1) begin
        seen = 1'b1;
        word = play_out;
      end
      step();
    end
  endtask : period
  task automatic capt(input logic [31:0] d);
    cap_in = d;
    cpoint = 1'b1;
    step();
    cpoint = 1'b0;
    repeat (3) step();
  endtask : capt
  initial begin
    rst = 1'b1;
    sstart = 1'b0;
    cpoint = 1'b0;
    cap_in = 32'h0;
    repeat (10) step();
    rst = 1'b0;
    step();
    ir(IDX_BASE_HI, 8'h00, "base_hi_rst");
    ir(IDX_BASE_LO, 8'h00, "base_lo_rst");
    iw(IDX_BASE_LO, 8'h34);
    iw(IDX_BASE_HI, 8'h12);
    ir(IDX_BASE_HI, 8'h12, "base_hi");
    ir(IDX_BASE_LO, 8'h34, "base_lo");
    ir(4'hD, 8'h00, "unmapped");
    // Playback DMA, 16-bit stereo
    iw(IDX_FORMAT, 8'h50);
    iw(IDX_IFACE, 8'h01);
    period();
    chk1("play_req", 1'b1, preq);
    chk1("cap_req_idle", 1'b0, creq);
    for (int i = 0; i < 4; i++) begin
      i_host.dma(1'b1, 1'b0, 8'(8'h11 * (i + 1)), q);
      if (i == 2) chk1("play_req_mid", 1'b1, preq);
    end
    chk1("play_req_done", 1'b0, preq);
    period();
    chk1("play_strobe", 1'b1, seen);
    chk32("play_word", 32'h44332211, word);
    // Capture PIO beside playback DMA, slow host
    iw(IDX_IFACE, 8'h83);
    capt(32'hD4C3B2A1);
    q = 8'h00;
    for (int i = 0; i < 8 && q[ST_CAP_READY_BIT] !== 1'b1; i++) stat();
    chk1("cap_ready", 1'b1, q[ST_CAP_READY_BIT]);
    rd(ADDR_PIO, 8'hA1, "pio_l_lo");
    rd(ADDR_PIO, 8'hB2, "pio_l_hi");
    rd(ADDR_PIO, 8'hC3, "pio_r_lo");
    rd(ADDR_PIO, 8'hD4, "pio_r_hi");
    chk1("cap_req_pio", 1'b0, creq);
    chk1("play_req_pend", 1'b1, preq);
    iw(IDX_IFACE, 8'h82);
    i_host.hold = 6;
    for (int i = 0; i < 4; i++) i_host.dma(1'b1, 1'b0, 8'h55, q);
    i_host.hold = 3;
    chk1("play_req_pio", 1'b0, preq);
    // Capture DMA, 8-bit mono
    iw(IDX_IFACE, 8'h00);
    iw(IDX_FORMAT, 8'h00);
    iw(IDX_IFACE, 8'h02);
    capt(32'h00005A00);
    chk1("cap_req", 1'b1, creq);
    i_host.dma(1'b0, 1'b1, 8'h00, q);
    chk8("cap_byte", 8'h5A, q);
    chk1("cap_req_done", 1'b0, creq);
    // Single channel
    iw(IDX_IFACE, 8'h00);
    iw(IDX_IFACE, 8'h06);
    capt(32'h00006B00);
    chk1("sc_play_req", 1'b1, preq);
    chk1("sc_cap_req", 1'b0, creq);
    i_host.dma(1'b0, 1'b1, 8'h00, q);
    chk1("sc_cap_ack_ign", 1'b1, preq);
    i_host.dma(1'b1, 1'b1, 8'h00, q);
    chk8("sc_byte", 8'h6B, q);
    chk1("sc_req_done", 1'b0, preq);
    iw(IDX_IFACE, 8'h00);
    iw(IDX_IFACE, 8'h07);
    period();
    chk1("sc_both_play", 1'b1, preq);
    i_host.dma(1'b1, 1'b0, 8'h01, q);
    capt(32'h0);
    chk1("sc_both_nocap", 1'b0, preq);
    chk1("sc_both_creq", 1'b0, creq);
    // Sample counter, interrupt and pin bits
    iw(IDX_IFACE, 8'h41);
    iw(IDX_BASE_LO, 8'h01);
    iw(IDX_BASE_HI, 8'h00);
    iw(IDX_PIN, 8'h00);
    wr(ADDR_STATUS, 8'h00);
    period();
    stat();
    chk1("int_early", 1'b0, q[ST_INT_BIT]);
    ir(IDX_BASE_LO, 8'h01, "base_lo_live");
    period();
    stat();
    chk1("int_set", 1'b1, q[ST_INT_BIT]);
    chk1("irq_masked", 1'b0, irq);
    iw(IDX_PIN, 8'h04);
    period();
    wr(ADDR_STATUS, 8'h00);
    iw(IDX_PIN, 8'h82);
    period();
    chk8("ext_ctl", 8'h02, {6'h00, ext_ctl});
    chk1("irq_reload", 1'b0, irq);
    period();
    chk1("irq_on", 1'b1, irq);
    wr(ADDR_STATUS, 8'h00);
    step();
    chk1("irq_clear", 1'b0, irq);
    conclude();
  end
endmodule : cht_host_port_tb
`default_nettype wire
